// >>> include/ssp_cfg.svh
// register map, field positions, reset values and bit constants
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_OFF_RCV_CTRL 8'h00
`define SSP_OFF_XMT_CTRL 8'h04
`define SSP_OFF_RATE 8'h08
`define SSP_OFF_RCV_DATA 8'h0C
`define SSP_OFF_XMT_DATA 8'h10
`define SSP_OFF_IRQ_FLAG 8'h14
`define SSP_OFF_IRQ_EN 8'h18
// receive_status_control fields
`define SSP_RC_PORT_EN 7
`define SSP_RC_NINTH_EN 6
`define SSP_RC_SINGLE_EN 5
`define SSP_RC_CONT_EN 4
`define SSP_RC_OVERRUN 1
`define SSP_RC_NINTH_BIT 0
// transmit_status_control fields
`define SSP_TC_CLK_MASTER 7
`define SSP_TC_NINTH_EN 6
`define SSP_TC_XMT_EN 5
`define SSP_TC_SYNC 4
`define SSP_TC_SHIFT_IDLE 1
`define SSP_TC_SEND_NINTH 0
// rate_control fields
`define SSP_RT_RCV_IDLE 6
`define SSP_RT_CLK_POL 4
// flag and enable fields
`define SSP_IF_RCV 5
`define SSP_IF_XMT 4
`define SSP_IE_PERIPH 7
`define SSP_RESET_BYTE 8'h00
`define SSP_RESET_XMT_CTRL 8'h02
`define SSP_BIT_CNT_W 4
`define SSP_WORD_8 4'h8
`define SSP_WORD_9 4'h9
`define SSP_FIFO_DEPTH 2
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_SLVERR 2'b10
`endif

// >>> include/ssp_pkg.sv
// types shared by the synchronous slave serial port
package ssp_pkg;
   typedef enum logic [1:0] {
      ssp_dir_off,
      ssp_dir_rcv,
      ssp_dir_xmt
   } ssp_dir_type;
   typedef logic [8:0] ssp_word_type;
endpackage : ssp_pkg

// >>> rtl/ssp_rx_fifo.sv
// small receive fifo, registered read data
`include "ssp_cfg.svh"
module ssp_rx_fifo
   import ssp_pkg::*;
#(
   parameter int DEPTH = `SSP_FIFO_DEPTH
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clken,
   input wire logic flush,
   input wire logic push,
   input wire ssp_word_type push_data,
   input wire logic pop,
   output logic full,
   output logic empty,
   output ssp_word_type head_ff
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   ssp_word_type mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   logic do_push;
   logic do_pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : ptr_inc

   assign full = (cnt_ff == (AW+1)'(DEPTH));
   assign empty = (cnt_ff == '0);
   assign do_push = push && !full;
   assign do_pop = pop && !empty;

   always_ff @(posedge aclk)
   begin
      if (clken && do_push)
      begin
         mem_ff[wr_ff] <= push_data;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || (clken && flush))
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end
      else if (clken)
      begin
         if (do_push)
         begin
            wr_ff <= ptr_inc(wr_ff);
         end
         if (do_pop)
         begin
            rd_ff <= ptr_inc(rd_ff);
         end
         cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // registered head: reflects the oldest entry one cycle later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         head_ff <= '0;
      end
      else if (clken)
      begin
         head_ff <= (cnt_ff == '0) ? '0 : mem_ff[rd_ff];
      end
   end
endmodule : ssp_rx_fifo

// >>> rtl/ssp_pin_sync.sv
// two-flop synchroniser for pin inputs
module ssp_pin_sync
   import ssp_pkg::*;
#(
   parameter int WIDTH = 2
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clken,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync_ff
);
   logic [WIDTH-1:0] meta_ff;

   // frozen with all other state: a pin level that changed meanwhile
   // shows up as one edge on restart
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_ff <= '0;
         pin_sync_ff <= '0;
      end
      else if (clken)
      begin
         meta_ff <= pin_async;
         pin_sync_ff <= meta_ff;
      end
   end
endmodule : ssp_pin_sync

// >>> rtl/ssp_top.sv
// synchronous slave serial port with axi4-lite register access
`include "ssp_cfg.svh"
module ssp_top
   import ssp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clken,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic transmit_or_clk_pin_i,
   input wire logic receive_or_data_pin_i,
   output logic receive_or_data_pin_o,
   output logic receive_or_data_pin_oe,
   output logic wake_ff
);
   ///////////////////////////////////////////////////////////////////////////
   logic [7:0] rcv_ctrl_ff;
   logic [7:0] xmt_ctrl_ff;
   logic [7:0] rate_ff;
   logic [7:0] irq_en_ff;
   logic [7:0] xmt_buf_ff;
   logic xmt_buf_ninth_ff;
   logic xmt_buf_full_ff;
   logic [8:0] xmt_shift_ff;
   logic [`SSP_BIT_CNT_W-1:0] xmt_cnt_ff;
   logic [8:0] rcv_shift_ff;
   logic [`SSP_BIT_CNT_W-1:0] rcv_cnt_ff;
   logic overrun_ff;
   logic rcv_ninth_ff;
   logic ck_last_ff;
   logic [1:0] pin_s;
   logic ck_edge;
   logic slave_mode;
   ssp_dir_type dir;
   logic [`SSP_BIT_CNT_W-1:0] word_len;
   logic rcv_word_done;
   logic fifo_full;
   logic fifo_empty;
   ssp_word_type fifo_head;
   logic fifo_pop;
   logic fifo_flush;
   logic aw_ok;
   logic ar_ok;
   logic [7:0] rd_byte;

   function automatic logic [7:0] reg_sel(input logic [7:0] a);
      reg_sel = {a[7:2], 2'b00};
   endfunction : reg_sel

   ssp_pin_sync #(.WIDTH(2)) u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .clken(clken),
      .pin_async({transmit_or_clk_pin_i, receive_or_data_pin_i}),
      .pin_sync_ff(pin_s)
   );

   ///////////////////////////////////////////////////////////////////////////
   // mode decode
   // slave select
   assign slave_mode = rcv_ctrl_ff[`SSP_RC_PORT_EN]
      && xmt_ctrl_ff[`SSP_TC_SYNC] && !xmt_ctrl_ff[`SSP_TC_CLK_MASTER];

   // single enable is only a direction hint
   always_comb
   begin
      dir = ssp_dir_off;
      if (slave_mode)
      begin
         if (!rcv_ctrl_ff[`SSP_RC_CONT_EN]
            && !rcv_ctrl_ff[`SSP_RC_SINGLE_EN])
         begin
            dir = ssp_dir_xmt;
         end
         else
         begin
            dir = ssp_dir_rcv;
         end
      end
   end

   assign word_len = rcv_ctrl_ff[`SSP_RC_NINTH_EN] ? `SSP_WORD_9
      : `SSP_WORD_8;

   // active edge of external clock, polarity selectable
   assign ck_edge = (pin_s[1] != ck_last_ff)
      && (pin_s[1] == !rate_ff[`SSP_RT_CLK_POL]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ck_last_ff <= 1'b0;
      end
      else if (clken)
      begin
         ck_last_ff <= pin_s[1];
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // receive shifter
   // receive armed only by continuous enable
   // lsb first into top of shifter
   always_ff @(posedge aclk)
   begin
      if (!aresetn || (clken && dir != ssp_dir_rcv)
         || (clken && !rcv_ctrl_ff[`SSP_RC_CONT_EN]))
      begin
         rcv_shift_ff <= '0;
         rcv_cnt_ff <= '0;
      end
      else if (clken && ck_edge)
      begin
         rcv_shift_ff <= {pin_s[0], rcv_shift_ff[8:1]};
         rcv_cnt_ff <= rcv_word_done ? '0
            : rcv_cnt_ff + `SSP_BIT_CNT_W'(1);
      end
   end

   assign rcv_word_done = ck_edge && dir == ssp_dir_rcv
      && rcv_ctrl_ff[`SSP_RC_CONT_EN]
      && (rcv_cnt_ff == word_len - `SSP_BIT_CNT_W'(1));

   logic [8:0] rcv_word;
   always_comb
   begin
      rcv_word = {pin_s[0], rcv_shift_ff[8:1]};
      if (!rcv_ctrl_ff[`SSP_RC_NINTH_EN])
      begin
         rcv_word = {1'b0, pin_s[0], rcv_shift_ff[8:2]};
      end
   end

   // port disable or receive disable clears fifo and overrun
   assign fifo_flush = !rcv_ctrl_ff[`SSP_RC_PORT_EN]
      || !rcv_ctrl_ff[`SSP_RC_CONT_EN];

   ssp_rx_fifo #(.DEPTH(`SSP_FIFO_DEPTH)) u_fifo
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .clken(clken),
      .flush(fifo_flush),
      .push(rcv_word_done && !overrun_ff),
      .push_data(rcv_word),
      .pop(fifo_pop),
      .full(fifo_full),
      .empty(fifo_empty),
      .head_ff(fifo_head)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         overrun_ff <= 1'b0;
      end
      else if (clken)
      begin
         if (rcv_word_done && fifo_full)
         begin
            overrun_ff <= 1'b1;
         end
         else if (fifo_flush)
         begin
            overrun_ff <= 1'b0;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // transmit side
   logic xmt_shift_busy;
   logic xmt_load;
   logic xmt_write;
   assign xmt_shift_busy = (xmt_cnt_ff != '0);
   assign xmt_write = aw_ok
      && reg_sel(s_axi_awaddr) == `SSP_OFF_XMT_DATA && s_axi_wstrb[0];
   // empty shifter takes the pending byte
   assign xmt_load = xmt_buf_full_ff && !xmt_shift_busy
      && dir == ssp_dir_xmt && xmt_ctrl_ff[`SSP_TC_XMT_EN];

   // write fills buffer, clears empty flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn || (clken && !rcv_ctrl_ff[`SSP_RC_PORT_EN]))
      begin
         xmt_buf_ff <= '0;
         xmt_buf_ninth_ff <= 1'b0;
         xmt_buf_full_ff <= 1'b0;
      end
      else if (clken)
      begin
         if (xmt_write)
         begin
            xmt_buf_ff <= s_axi_wdata[7:0];
            xmt_buf_ninth_ff <= xmt_ctrl_ff[`SSP_TC_SEND_NINTH];
            xmt_buf_full_ff <= 1'b1;
         end
         else if (xmt_load)
         begin
            xmt_buf_full_ff <= 1'b0;
         end
      end
   end

   // shift out on external clock edges
   always_ff @(posedge aclk)
   begin
      if (!aresetn || (clken && dir != ssp_dir_xmt))
      begin
         xmt_shift_ff <= '0;
         xmt_cnt_ff <= '0;
      end
      else if (clken)
      begin
         if (xmt_load)
         begin
            xmt_shift_ff <= {xmt_buf_ninth_ff, xmt_buf_ff};
            xmt_cnt_ff <= xmt_ctrl_ff[`SSP_TC_NINTH_EN] ? `SSP_WORD_9
               : `SSP_WORD_8;
         end
         else if (ck_edge && xmt_shift_busy)
         begin
            xmt_shift_ff <= {1'b0, xmt_shift_ff[8:1]};
            xmt_cnt_ff <= xmt_cnt_ff - `SSP_BIT_CNT_W'(1);
         end
      end
   end

   // data pin driven only in transmit direction
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         receive_or_data_pin_o <= 1'b0;
         receive_or_data_pin_oe <= 1'b0;
      end
      else if (clken)
      begin
         receive_or_data_pin_o <= xmt_shift_ff[0];
         receive_or_data_pin_oe <= dir == ssp_dir_xmt
            && xmt_ctrl_ff[`SSP_TC_XMT_EN];
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // flags and wake
   logic rcv_flag;
   logic xmt_flag;
   assign rcv_flag = !fifo_empty;
   assign xmt_flag = !xmt_buf_full_ff;

   // wake follows enabled events in slave mode
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_ff <= 1'b0;
      end
      else if (clken)
      begin
         wake_ff <= irq_en_ff[`SSP_IE_PERIPH] && slave_mode
            && ((rcv_flag && irq_en_ff[`SSP_IF_RCV])
            || (xmt_flag && irq_en_ff[`SSP_IF_XMT]
            && xmt_ctrl_ff[`SSP_TC_XMT_EN]));
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // axi4-lite write
   assign aw_ok = clken && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rcv_ctrl_ff <= `SSP_RESET_BYTE;
         xmt_ctrl_ff <= `SSP_RESET_BYTE;
         rate_ff <= `SSP_RESET_BYTE;
         irq_en_ff <= `SSP_RESET_BYTE;
      end
      else if (aw_ok && s_axi_wstrb[0])
      begin
         case (reg_sel(s_axi_awaddr))
            `SSP_OFF_RCV_CTRL: rcv_ctrl_ff <= s_axi_wdata[7:0];
            `SSP_OFF_XMT_CTRL: xmt_ctrl_ff <= s_axi_wdata[7:0];
            `SSP_OFF_RATE: rate_ff <= s_axi_wdata[7:0];
            `SSP_OFF_IRQ_EN: irq_en_ff <= s_axi_wdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SSP_RESP_OKAY;
      end
      else if (clken)
      begin
         s_axi_awready <= aw_ok && !s_axi_awready;
         s_axi_wready <= aw_ok && !s_axi_awready;
         if (aw_ok && !s_axi_awready)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (reg_sel(s_axi_awaddr) > `SSP_OFF_IRQ_EN
               || reg_sel(s_axi_awaddr) == `SSP_OFF_RCV_DATA
               || reg_sel(s_axi_awaddr) == `SSP_OFF_IRQ_FLAG)
               ? `SSP_RESP_SLVERR : `SSP_RESP_OKAY;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // axi4-lite read
   assign ar_ok = clken && s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
   assign fifo_pop = ar_ok
      && reg_sel(s_axi_araddr) == `SSP_OFF_RCV_DATA;

   always_comb
   begin
      rd_byte = rcv_ctrl_ff;
      case (reg_sel(s_axi_araddr))
         `SSP_OFF_RCV_CTRL:
         begin
            // ninth bit and overrun in status
            rd_byte = rcv_ctrl_ff;
            rd_byte[`SSP_RC_OVERRUN] = overrun_ff;
            rd_byte[`SSP_RC_NINTH_BIT] = fifo_head[8];
         end
         `SSP_OFF_XMT_CTRL:
         begin
            rd_byte = xmt_ctrl_ff;
            rd_byte[`SSP_TC_SHIFT_IDLE] = !xmt_shift_busy;
         end
         `SSP_OFF_RATE:
         begin
            rd_byte = rate_ff;
            rd_byte[`SSP_RT_RCV_IDLE] = !(dir == ssp_dir_rcv);
         end
         `SSP_OFF_RCV_DATA: rd_byte = fifo_head[7:0];
         `SSP_OFF_IRQ_FLAG:
         begin
            rd_byte = `SSP_RESET_BYTE;
            rd_byte[`SSP_IF_RCV] = rcv_flag;
            rd_byte[`SSP_IF_XMT] = xmt_flag;
         end
         `SSP_OFF_IRQ_EN: rd_byte = irq_en_ff;
         default: rd_byte = `SSP_RESET_BYTE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `SSP_RESP_OKAY;
      end
      else if (clken)
      begin
         s_axi_arready <= ar_ok;
         if (ar_ok)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= (reg_sel(s_axi_araddr) > `SSP_OFF_IRQ_EN
               || reg_sel(s_axi_araddr) == `SSP_OFF_XMT_DATA)
               ? `SSP_RESP_SLVERR : `SSP_RESP_OKAY;
         end
         else if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // checks
   overrun_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      overrun_ff && clken && !fifo_flush |=> overrun_ff)
      else $error("overrun lost while enabled");
   xmt_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      xmt_write && rcv_ctrl_ff[`SSP_RC_PORT_EN] |=> !xmt_flag)
      else $error("buffer write left empty flag set");
   dir_xmt_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clken && slave_mode && !rcv_ctrl_ff[`SSP_RC_CONT_EN]
      && !rcv_ctrl_ff[`SSP_RC_SINGLE_EN]
      && xmt_ctrl_ff[`SSP_TC_XMT_EN] |=> receive_or_data_pin_oe)
      else $error("data pin not driven in transmit direction");
   rcv_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clken && !ck_edge && dir == ssp_dir_rcv
      && rcv_ctrl_ff[`SSP_RC_CONT_EN] |=> $stable(rcv_cnt_ff))
      else $error("receive shifter moved without clock");
   rcv_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rcv_word_done && clken && !fifo_full && !overrun_ff |=> rcv_flag)
      else $error("done flag not set");
   wake_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !irq_en_ff[`SSP_IE_PERIPH] ##1 !irq_en_ff[`SSP_IE_PERIPH] |-> !wake_ff)
      else $error("wake without enable");
   pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clken && dir != ssp_dir_xmt |=> !receive_or_data_pin_oe)
      else $error("data pin driven while receiving");
   xmt_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      xmt_load && clken && !xmt_write |=> xmt_flag && xmt_shift_busy)
      else $error("shifter load failed");
   rcv_word_c: cover property (@(posedge aclk) rcv_word_done);
   xmt_load_c: cover property (@(posedge aclk) xmt_load);
   overrun_c: cover property (@(posedge aclk) overrun_ff);
endmodule : ssp_top

// >>> bench/ssp_link_master.sv
// external synchronous master model: shift clock and data pin
module ssp_link_master
(
   input wire logic aclk,
   input wire logic data_line,
   output logic clk_pin,
   output logic data_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idle_lvl;
   initial
   begin
      idle_lvl = 1'b0;
      clk_pin = 1'b0;
      data_pin = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // half of the 80 ns link period, counted in aclk cycles
   task automatic half();
      repeat (8) @(posedge aclk);
   endtask : half
   // idle level decides which clock edge is the active one
   task automatic set_idle(input logic v);
      idle_lvl = v;
      clk_pin <= v;
      half();
   endtask : set_idle
   task automatic xfer(input logic [8:0] w, input int nb, input logic drv,
      output logic [8:0] got);
      got = 9'h000;
      for (int i = 0; i < nb; i++)
      begin
         data_pin <= drv ? w[i] : ~data_pin;
         half();
         got[i] = data_line;
         clk_pin <= ~idle_lvl;
         half();
         clk_pin <= idle_lvl;
      end
      // released line must not keep the last bit
      data_pin <= ~data_pin;
      half();
   endtask : xfer
endmodule : ssp_link_master

// >>> bench/tb_ssp_top.sv
// self-checking bench for the slave serial port
module tb_ssp_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic ck_pin, m_data, pin_o, pin_oe, wake_ff, data_line;
   logic clken;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [8:0] w, got;
   logic [7:0] t0, t1;
   int err_count, n_tests, seed;
   assign data_line = pin_oe ? pin_o : m_data;
   ssp_top ssp_top_inst
   (
      .aclk(aclk), .aresetn(aresetn), .clken(clken),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .transmit_or_clk_pin_i(ck_pin), .receive_or_data_pin_i(data_line),
      .receive_or_data_pin_o(pin_o), .receive_or_data_pin_oe(pin_oe),
      .wake_ff(wake_ff)
   );
   ssp_link_master ssp_link_master_inst
   (
      .aclk(aclk), .data_line(data_line), .clk_pin(ck_pin),
      .data_pin(m_data)
   );
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (err_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk
   // expected flag register from the two pending conditions
   function automatic logic [31:0] flag_exp(input logic rcv,
      input logic xmt);
      flag_exp = {26'h0, rcv, xmt, 4'h0};
   endfunction : flag_exp
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] er);
      int n;
      logic [1:0] tk;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      tk = 2'b00;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         tk = tk | {awready, wready};
      end
      while (!bvalid && n < 64);
      bready <= 1'b0;
      if (n >= 64)
      begin
         err_count++;
         end_of_test();
      end
      chk("bresp", 32'(er), 32'(bresp));
      chk("aw w taken", 32'h3, 32'(tk));
   endtask : wr
   // masked read compare, response checked in full
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input logic [1:0] er);
      int n;
      logic tk;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      tk = 1'b0;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
         tk = tk | arready;
      end
      while (!rvalid && n < 64);
      rready <= 1'b0;
      if (n >= 64)
      begin
         err_count++;
         end_of_test();
      end
      chk("rdata", e & m, rdata & m);
      chk("rresp", 32'(er), 32'(rresp));
      chk("ar taken", 32'h1, 32'(tk));
   endtask : rd
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 49613;
      err_count = 0;
      n_tests = 0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      clken = 1'b1;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 32'hff, 32'h00, 2'b00);
      rd(8'h04, 32'hff, 32'h02, 2'b00);
      rd(8'h1c, 32'hffff_ffff, 32'h0, 2'b10);
      rd(8'h10, 32'hffff_ffff, 32'h0, 2'b10);
      wr(8'h0c, 8'hff, 2'b10);
      // slave receive with irq on receive
      wr(8'h04, 8'h10, 2'b00);
      wr(8'h18, 8'ha0, 2'b00);
      wr(8'h00, 8'h90, 2'b00);
      for (int k = 0; k < 4; k++)
      begin
         w = (k == 0) ? 9'h001 : 9'($random(seed));
         ssp_link_master_inst.xfer(w, 8, 1'b1, got);
         rd(8'h14, 32'h20, 32'h20, 2'b00);
         chk("wake", 32'h1, 32'(wake_ff));
         rd(8'h0c, 32'hff, 32'(w[7:0]), 2'b00);
         rd(8'h14, 32'h20, 32'h00, 2'b00);
         chk("wake", 32'h0, 32'(wake_ff));
      end
      // three words into a two-deep fifo
      t0 = 8'($random(seed));
      t1 = 8'($random(seed));
      ssp_link_master_inst.xfer({1'b0, t0}, 8, 1'b1, got);
      ssp_link_master_inst.xfer({1'b0, t1}, 8, 1'b1, got);
      ssp_link_master_inst.xfer(9'h0a5, 8, 1'b1, got);
      rd(8'h00, 32'h02, 32'h02, 2'b00);
      rd(8'h0c, 32'hff, 32'(t0), 2'b00);
      rd(8'h0c, 32'hff, 32'(t1), 2'b00);
      rd(8'h00, 32'h02, 32'h02, 2'b00);
      wr(8'h00, 8'h80, 2'b00);
      rd(8'h00, 32'h02, 32'h00, 2'b00);
      // nine-bit words, single enable set as well
      wr(8'h00, 8'hf0, 2'b00);
      for (int j = 0; j < 2; j++)
      begin
         w = 9'($random(seed));
         w[8] = (j == 0);
         ssp_link_master_inst.xfer(w, 9, 1'b1, got);
         rd(8'h00, 32'h01, 32'(w[8]), 2'b00);
         rd(8'h0c, 32'hff, 32'(w[7:0]), 2'b00);
      end
      // back to eight-bit words, irq on receive still enabled
      wr(8'h00, 8'h90, 2'b00);
      // frozen block must ignore a whole word on the link
      clken <= 1'b0;
      ssp_link_master_inst.xfer(9'h0c3, 8, 1'b1, got);
      clken <= 1'b1;
      rd(8'h14, 32'h20, flag_exp(1'b0, 1'b1), 2'b00);
      // falling clock edge active
      wr(8'h08, 8'h10, 2'b00);
      rd(8'h08, 32'h50, 32'h10, 2'b00);
      ssp_link_master_inst.set_idle(1'b1);
      t0 = 8'($random(seed));
      ssp_link_master_inst.xfer({1'b0, t0}, 8, 1'b1, got);
      rd(8'h0c, 32'hff, 32'(t0), 2'b00);
      wr(8'h08, 8'h00, 2'b00);
      ssp_link_master_inst.set_idle(1'b0);
      wr(8'h18, 8'h80, 2'b00);
      ssp_link_master_inst.xfer(9'h0ff, 8, 1'b1, got);
      rd(8'h14, 32'h20, 32'h20, 2'b00);
      chk("wake", 32'h0, 32'(wake_ff));
      rd(8'h0c, 32'hff, 32'hff, 2'b00);
      // slave transmit: both receive enables clear
      wr(8'h00, 8'h80, 2'b00);
      wr(8'h04, 8'h30, 2'b00);
      wr(8'h18, 8'h90, 2'b00);
      t0 = 8'($random(seed));
      t1 = 8'($random(seed));
      wr(8'h10, t0, 2'b00);
      wr(8'h10, t1, 2'b00);
      rd(8'h14, 32'h10, flag_exp(1'b0, 1'b0), 2'b00);
      chk("oe", 32'h1, 32'(pin_oe));
      ssp_link_master_inst.xfer(9'h000, 8, 1'b0, got);
      chk("tx word", 32'(t0), 32'(got[7:0]));
      rd(8'h14, 32'h10, flag_exp(1'b0, 1'b1), 2'b00);
      chk("wake", 32'h1, 32'(wake_ff));
      ssp_link_master_inst.xfer(9'h000, 8, 1'b0, got);
      chk("tx word", 32'(t1), 32'(got[7:0]));
      // nine-bit send with the ninth bit set
      wr(8'h04, 8'h71, 2'b00);
      wr(8'h10, t0, 2'b00);
      ssp_link_master_inst.xfer(9'h000, 9, 1'b0, got);
      chk("tx word", 32'({1'b1, t0}), 32'(got));
      rd(8'h04, 32'hff, 32'h73, 2'b00);
      end_of_test();
   end
endmodule : tb_ssp_top
